// *** rtl/ssra_defines.svh ***
// shared constants for the sensor serial register port, both ends
// assumes a 200 MHz system clock on each end
`ifndef SSRA_DEFINES_SVH
`define SSRA_DEFINES_SVH
// ============================================================
// register offsets (16-bit address field)
`define SSRA_ADDR_LINE_LENGTH 16'h0200
`define SSRA_ADDR_LVDS_SEL    16'h2449
`define SSRA_ADDR_RDY_EN      16'h4041
// ============================================================
// field layout
`define SSRA_ADDR_W           16
`define SSRA_DATA_W           16
`define SSRA_CMD_W            8
`define SSRA_CMD_WRITE        8'h01
`define SSRA_CMD_READ         8'h02
`define SSRA_FRAME_BITS       40
`define SSRA_HDR_BITS         24
`define SSRA_RDY_EN_BIT       0
`define SSRA_LVDS_SUB_BIT     0
// ============================================================
// reset values
`define SSRA_RST_LINE_LENGTH  16'h0000
`define SSRA_RST_LVDS_SEL     16'h0000
`define SSRA_RST_RDY_EN       16'h0000
// ============================================================
// timing: clock period in ps, fetch times in ns
`define SSRA_CLK_PS           5000
`define SSRA_FETCH_SETUP_NS   1500
`define SSRA_FETCH_STREAM_NS  4500
`define SSRA_FETCH_SETUP_CYC  ((`SSRA_FETCH_SETUP_NS*1000)/`SSRA_CLK_PS)
`define SSRA_FETCH_STREAM_CYC \
  ((`SSRA_FETCH_STREAM_NS*1000+`SSRA_CLK_PS-1)/`SSRA_CLK_PS)
`define SSRA_FETCH_FAST_CYC   1
// ============================================================
// controller side: serial clock half period less one, in system clocks
`define SSRA_SCK_HALF         8'h08
// ============================================================
// controller register offsets, byte addresses
`define SSRA_CSR_CTRL         4'h0
`define SSRA_CSR_ADDR         4'h4
`define SSRA_CSR_WDATA        4'h8
`define SSRA_CSR_STATUS       4'hC
`endif

// *** rtl/ssra_pkg.sv ***
// types shared by the sensor serial register port ends
// assumes nothing beyond the defines header
package ssra_pkg;
  typedef enum logic [1:0] {
    SSRA_OP_SETUP,
    SSRA_OP_STREAM,
    SSRA_OP_STANDBY
  } ssra_op_state_t;
endpackage : ssra_pkg

// *** rtl/ssra_if.sv ***
// serial link between controller and sensor register port
// assumes the bench joins both modports and resolves no tristate
`timescale 1ns/100ps
interface ssra_if;
  logic sck;
  logic sel_b;
  logic mosi;
  logic miso;
  logic read_ready_flag;
  modport ctrl
  (
    output sck,
    output sel_b,
    output mosi,
    input  miso,
    input  read_ready_flag
  );
  modport dev
  (
    input  sck,
    input  sel_b,
    input  mosi,
    output miso,
    output read_ready_flag
  );
endinterface : ssra_if

// *** rtl/ssra_device.sv ***
// sensor end of the serial register port: slave, shadow and active copies
// assumes link pins are asynchronous and are sampled by ref_clk_in
`timescale 1ns/100ps
`include "ssra_defines.svh"
module ssra_device
  import ssra_pkg::*;
(
  input  wire logic           ref_clk_in,
  input  wire logic           rst_b_in,
  ssra_if.dev                 link,
  input  wire ssra_op_state_t op_state_in,
  input  wire logic           frame_start_in,
  output logic [15:0]         line_length_out,
  output logic [15:0]         lvds_sel_out,
  output logic                sub_lvds_out
);
  // ==========================================================
  // pin synchronisers
  logic [1:0] sck_s_r;
  logic [1:0] sel_s_r;
  logic [1:0] mosi_s_r;
  logic       sck_d_r;
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
    begin
      sck_s_r  <= 2'h3;
      sel_s_r  <= 2'h3;
      mosi_s_r <= 2'h0;
      sck_d_r  <= 1'b1;
    end
    else
    begin
      sck_s_r  <= {sck_s_r[0], link.sck};
      sel_s_r  <= {sel_s_r[0], link.sel_b};
      mosi_s_r <= {mosi_s_r[0], link.mosi};
      sck_d_r  <= sck_s_r[1];
    end
  end
  logic sck_v;
  logic sel_act;
  logic sck_rise;
  logic sck_fall;
  assign sck_v    = sck_s_r[1];
  assign sel_act  = !sel_s_r[1];
  assign sck_rise = sel_act && sck_v && !sck_d_r;
  assign sck_fall = sel_act && !sck_v && sck_d_r;
  // ==========================================================
  // shift-in of command, address and data
  logic [39:0] sh_r;
  logic [5:0]  bit_cnt_r;
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in || !sel_act)
    begin
      sh_r      <= 40'h0;
      bit_cnt_r <= 6'h00;
    end
    else if (sck_rise && bit_cnt_r != 6'(`SSRA_FRAME_BITS))
    begin
      sh_r      <= {sh_r[38:0], mosi_s_r[1]};
      bit_cnt_r <= bit_cnt_r + 6'h01;
    end
  end
  logic        hdr_done;
  logic        is_read;
  logic        wr_commit;
  logic [15:0] hdr_addr;
  assign hdr_done  = sck_rise && bit_cnt_r == 6'h17;
  assign is_read   = sh_r[22:15] == `SSRA_CMD_READ;
  assign hdr_addr  = {sh_r[14:0], mosi_s_r[1]};
  // only the final bit commits, so a cut frame writes nothing
  assign wr_commit = sck_rise && bit_cnt_r == 6'h27
                     && sh_r[38:31] == `SSRA_CMD_WRITE;
  logic [15:0] wr_addr;
  logic [15:0] wr_data;
  assign wr_addr = sh_r[30:15];
  assign wr_data = {sh_r[14:0], mosi_s_r[1]};
  // ==========================================================
  // shadow storage
  logic [15:0] sh_ll_r;
  logic [15:0] sh_lvds_r;
  logic [15:0] sh_rdy_r;
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
    begin
      sh_ll_r   <= `SSRA_RST_LINE_LENGTH;
      sh_lvds_r <= `SSRA_RST_LVDS_SEL;
      sh_rdy_r  <= `SSRA_RST_RDY_EN;
    end
    else if (wr_commit)
    begin
      unique case (wr_addr)
        `SSRA_ADDR_LINE_LENGTH: sh_ll_r   <= wr_data;
        `SSRA_ADDR_LVDS_SEL:    sh_lvds_r <= wr_data;
        `SSRA_ADDR_RDY_EN:      sh_rdy_r  <= wr_data;
        default:                ;
      endcase
    end
  end
  // ==========================================================
  // active storage
  logic           enter_setup;
  ssra_op_state_t op_d_r;
  logic [15:0]    act_rdy_r;
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
      op_d_r <= SSRA_OP_STANDBY;
    else
      op_d_r <= op_state_in;
  end
  assign enter_setup = op_state_in == SSRA_OP_SETUP
                       && op_d_r != SSRA_OP_SETUP;
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
      line_length_out <= `SSRA_RST_LINE_LENGTH;
    else if (enter_setup)
      line_length_out <= sh_ll_r;
  end
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
    begin
      lvds_sel_out <= `SSRA_RST_LVDS_SEL;
      sub_lvds_out <= 1'b0;
      act_rdy_r    <= `SSRA_RST_RDY_EN;
    end
    else if (frame_start_in || enter_setup)
    begin
      lvds_sel_out <= sh_lvds_r;
      sub_lvds_out <= sh_lvds_r[`SSRA_LVDS_SUB_BIT];
      act_rdy_r    <= sh_rdy_r;
    end
  end
  // ==========================================================
  // read fetch: delay depends on register and operating state
  logic [9:0]  fetch_cnt_r;
  logic        fetching_r;
  logic        ready_r;
  logic [15:0] rd_word_r;
  logic [9:0]  fetch_len;
  always_comb
  begin
    if (hdr_addr == `SSRA_ADDR_RDY_EN)
      fetch_len = 10'(`SSRA_FETCH_FAST_CYC);
    else if (op_state_in == SSRA_OP_STREAM)
      fetch_len = 10'(`SSRA_FETCH_STREAM_CYC);
    else
      fetch_len = 10'(`SSRA_FETCH_SETUP_CYC);
  end
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in || !sel_act)
    begin
      fetching_r  <= 1'b0;
      ready_r     <= 1'b0;
      fetch_cnt_r <= 10'h000;
      rd_word_r   <= 16'h0000;
    end
    else if (hdr_done && is_read)
    begin
      fetching_r  <= 1'b1;
      ready_r     <= 1'b0;
      fetch_cnt_r <= fetch_len;
      unique case (hdr_addr)
        `SSRA_ADDR_LINE_LENGTH: rd_word_r <= sh_ll_r;
        `SSRA_ADDR_LVDS_SEL:    rd_word_r <= sh_lvds_r;
        `SSRA_ADDR_RDY_EN:      rd_word_r <= sh_rdy_r;
        default:                rd_word_r <= 16'h0000;
      endcase
    end
    else if (fetching_r)
    begin
      if (fetch_cnt_r <= 10'h001)
      begin
        fetching_r <= 1'b0;
        ready_r    <= 1'b1;
      end
      else
        fetch_cnt_r <= fetch_cnt_r - 10'h001;
    end
    // first data-phase fall keeps bit 15, already standing since ready
    else if (ready_r && sck_fall && bit_cnt_r != 6'(`SSRA_HDR_BITS))
      rd_word_r <= {rd_word_r[14:0], 1'b0};
  end
  // ==========================================================
  // pin outputs: slave only, never drives the clock
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
    begin
      link.miso            <= 1'b0;
      link.read_ready_flag <= 1'b0;
    end
    else
    begin
      // launch on falling edge so the controller samples on rising
      link.miso <= ready_r && sel_act && rd_word_r[15];
      link.read_ready_flag <= act_rdy_r[`SSRA_RDY_EN_BIT]
                              && ready_r;
    end
  end
endmodule : ssra_device

// *** rtl/ssra_ctrl.sv ***
// controller end: Avalon-MM slave registers, serial master on the link
// assumes the device end samples the link pins with its own clock
`timescale 1ns/100ps
`include "ssra_defines.svh"
module ssra_ctrl
  import ssra_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        rst_b_in,
  input  wire logic [3:0]  avm_address_in,
  input  wire logic        avm_read_in,
  input  wire logic        avm_write_in,
  input  wire logic [31:0] avm_writedata_in,
  output logic [31:0]      avm_readdata_out,
  output logic             avm_waitrequest_out,
  ssra_if.ctrl             link
);
  typedef enum logic [2:0] {
    SSRA_C_IDLE, SSRA_C_HDR, SSRA_C_WAIT, SSRA_C_DATA, SSRA_C_END
  } ssra_cstate_t;
  // ==========================================================
  // register file
  logic [15:0]  addr_r;
  logic [15:0]  wdata_r;
  logic [15:0]  rdata_r;
  logic         use_flag_r;
  logic         is_rd_r;
  logic         go;
  ssra_cstate_t st_r;
  logic [1:0]   flag_s_r;
  logic [1:0]   miso_s_r;
  logic         bus_ack_r;
  assign go = avm_write_in && bus_ack_r && avm_address_in
              == `SSRA_CSR_CTRL && st_r == SSRA_C_IDLE;
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
    begin
      addr_r     <= 16'h0000;
      wdata_r    <= 16'h0000;
      use_flag_r <= 1'b0;
      is_rd_r    <= 1'b0;
    end
    // writes land only at the edge that ends the wait
    else if (avm_write_in && bus_ack_r)
    begin
      unique case (avm_address_in)
        `SSRA_CSR_ADDR:  addr_r  <= avm_writedata_in[15:0];
        `SSRA_CSR_WDATA: wdata_r <= avm_writedata_in[15:0];
        `SSRA_CSR_CTRL:
        begin
          if (st_r == SSRA_C_IDLE)
          begin
            is_rd_r    <= avm_writedata_in[0];
            use_flag_r <= avm_writedata_in[1];
          end
        end
        default: ;
      endcase
    end
  end
  // one wait cycle, then answer; unmapped reads give zero
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
    begin
      bus_ack_r           <= 1'b0;
      avm_waitrequest_out <= 1'b1;
      avm_readdata_out    <= 32'h0000_0000;
    end
    else
    begin
      bus_ack_r <= (avm_read_in || avm_write_in) && !bus_ack_r;
      avm_waitrequest_out <= !((avm_read_in || avm_write_in)
                               && !bus_ack_r);
      unique case (avm_address_in)
        `SSRA_CSR_ADDR:   avm_readdata_out <= {16'h0000, addr_r};
        `SSRA_CSR_WDATA:  avm_readdata_out <= {16'h0000, wdata_r};
        `SSRA_CSR_STATUS: avm_readdata_out <=
          {15'h0000, st_r != SSRA_C_IDLE, rdata_r};
        default:          avm_readdata_out <= 32'h0000_0000;
      endcase
    end
  end
  // ==========================================================
  // serial master: clock idles high, launch on fall
  logic [7:0]  div_r;
  logic [5:0]  bits_r;
  logic [31:0] tx_r;
  logic [11:0] wait_r;
  logic        tick;
  assign tick = div_r == 8'h00;
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
    begin
      flag_s_r <= 2'h0;
      miso_s_r <= 2'h0;
    end
    else
    begin
      flag_s_r <= {flag_s_r[0], link.read_ready_flag};
      miso_s_r <= {miso_s_r[0], link.miso};
    end
  end
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in || st_r == SSRA_C_IDLE || tick)
      div_r <= `SSRA_SCK_HALF;
    else
      div_r <= div_r - 8'h01;
  end
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
    begin
      st_r       <= SSRA_C_IDLE;
      link.sck   <= 1'b1;
      link.sel_b <= 1'b1;
      link.mosi  <= 1'b0;
      bits_r     <= 6'h00;
      tx_r       <= 32'h0;
      wait_r     <= 12'h000;
      rdata_r    <= 16'h0000;
    end
    else
    begin
      unique case (st_r)
        SSRA_C_IDLE:
        begin
          if (go)
          begin
            st_r       <= SSRA_C_HDR;
            link.sel_b <= 1'b0;
            bits_r     <= 6'h28;
            // command then address, most significant first; data loads after the header
            tx_r <= {avm_writedata_in[0] ? `SSRA_CMD_READ
                     : `SSRA_CMD_WRITE, addr_r, 8'h00};
          end
        end
        SSRA_C_HDR, SSRA_C_DATA:
        begin
          if (tick)
          begin
            link.sck <= !link.sck;
            if (link.sck)
            begin
              link.mosi <= st_r == SSRA_C_HDR ? tx_r[31] : wdata_r[15];
              tx_r      <= {tx_r[30:0], 1'b0};
            end
            else
            begin
              bits_r <= bits_r - 6'h01;
              if (st_r == SSRA_C_DATA)
              begin
                rdata_r <= {rdata_r[14:0], miso_s_r[1]};
                if (!is_rd_r)
                  tx_r <= tx_r;
              end
              if (bits_r == 6'h11)
              begin
                st_r   <= is_rd_r ? SSRA_C_WAIT : SSRA_C_DATA;
                tx_r   <= {wdata_r, 16'h0000};
                wait_r <= 12'(`SSRA_FETCH_STREAM_CYC);
              end
              if (bits_r == 6'h01)
                st_r <= SSRA_C_END;
            end
            if (st_r == SSRA_C_DATA && link.sck)
              link.mosi <= tx_r[31];
          end
        end
        SSRA_C_WAIT:
        begin
          wait_r <= wait_r - 12'h001;
          if ((use_flag_r && flag_s_r[1])
              || wait_r == 12'h000)
            st_r <= SSRA_C_DATA;
        end
        SSRA_C_END:
        begin
          if (tick)
          begin
            link.sel_b <= 1'b1;
            st_r       <= SSRA_C_IDLE;
          end
        end
      endcase
    end
  end
endmodule : ssra_ctrl

// *** testbench/ssra_link_sva.sv ***
// link checker for the sensor serial register port
// assumes both ends share ref_clk_in and the synchronous active-low reset
`timescale 1ns/100ps
module ssra_link_sva
(
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic sck,
  input wire logic sel_b,
  input wire logic mosi,
  input wire logic miso,
  input wire logic read_ready_flag
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_b_in);
  // ==========================================================
  // serial clock framing
  a_sck_idle_high: assert property (sel_b |-> sck)
    else $error("serial clock low while deselected");
  a_sck_only_sel: assert property ($fell(sck) |-> !sel_b)
    else $error("serial clock toggled without select");
  a_desel_after_high: assert property ($rose(sel_b) |-> $past(sck))
    else $error("select released with clock low");
  // divider output, never a glitch
  a_sck_half_span: assert property ($changed(sck) |=> $stable(sck)[*7])
    else $error("serial clock half period too short");
  // ==========================================================
  // data launch and sample edges
  a_mosi_steady_rise: assert property ($rose(sck) |-> $stable(mosi))
    else $error("mosi moved at sampling edge");
  a_miso_steady_rise: assert property ($rose(sck) && !sel_b |-> $stable(miso))
    else $error("miso moved at sampling edge");
  // ==========================================================
  // ready flag handshake
  a_flag_in_frame: assert property ($rose(read_ready_flag) |-> !sel_b && sck)
    else $error("ready flag rose outside a paused read");
  a_flag_holds: assert property (read_ready_flag && !sel_b |=> read_ready_flag)
    else $error("ready flag dropped inside frame");
  cover property ($rose(read_ready_flag));
  cover property ($fell(sel_b));
  cover property (!sel_b && $rose(sck) && miso);
endmodule : ssra_link_sva

// *** testbench/sensor_spi_register_access_bench.sv ***
// bench joining controller and sensor ends over the serial link
// assumes one 200 MHz clock for both ends and Avalon-MM to the controller
`timescale 1ns/100ps
`include "ssra_defines.svh"
module sensor_spi_register_access_bench
  import ssra_pkg::*;
;
  logic           clk;
  logic           rst_b;
  logic [3:0]     av_addr;
  logic           av_rd;
  logic           av_wr;
  logic [31:0]    av_wdata;
  logic [31:0]    av_rdata;
  logic           av_wait;
  ssra_op_state_t op_state;
  logic           frame_start;
  logic [15:0]    line_length_act;
  logic [15:0]    lvds_sel_act;
  logic           sub_lvds_act;
  logic [39:0]    wire_bits;
  int             wait_cyc = 0;
  int             n_errors = 0;
  int             cmp_count = 0;
  localparam int  FETCH_MAX = 48 * (`SSRA_SCK_HALF + 1)
                              + `SSRA_FETCH_SETUP_CYC + 32;
  ssra_if ssra_if_inst ();
  // ==========================================================
  // ends and checker
  ssra_ctrl ssra_ctrl_inst
  (
    .ref_clk_in          (clk),
    .rst_b_in            (rst_b),
    .avm_address_in      (av_addr),
    .avm_read_in         (av_rd),
    .avm_write_in        (av_wr),
    .avm_writedata_in    (av_wdata),
    .avm_readdata_out    (av_rdata),
    .avm_waitrequest_out (av_wait),
    .link                (ssra_if_inst.ctrl)
  );
  ssra_device ssra_device_inst
  (
    .ref_clk_in      (clk),
    .rst_b_in        (rst_b),
    .link            (ssra_if_inst.dev),
    .op_state_in     (op_state),
    .frame_start_in  (frame_start),
    .line_length_out (line_length_act),
    .lvds_sel_out    (lvds_sel_act),
    .sub_lvds_out    (sub_lvds_act)
  );
  ssra_link_sva ssra_link_sva_inst
  (
    .ref_clk_in      (clk),
    .rst_b_in        (rst_b),
    .sck             (ssra_if_inst.sck),
    .sel_b           (ssra_if_inst.sel_b),
    .mosi            (ssra_if_inst.mosi),
    .miso            (ssra_if_inst.miso),
    .read_ready_flag (ssra_if_inst.read_ready_flag)
  );
  // ==========================================================
  // wire watchers: frame capture and wait-for-flag span
  always @(posedge ssra_if_inst.sck)
    if (!ssra_if_inst.sel_b)
      wire_bits <= {wire_bits[38:0], ssra_if_inst.mosi};
  always @(posedge clk)
    if (!ssra_if_inst.sel_b && !ssra_if_inst.read_ready_flag)
      wait_cyc <= wait_cyc + 1;
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ==========================================================
  // shared tasks
  task automatic chk(input logic [39:0] got, input logic [39:0] exp,
                     input string what);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic av(input logic wr, input logic [3:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    av_addr  <= a;
    av_wr    <= wr;
    av_rd    <= !wr;
    av_wdata <= d;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (av_wait !== 1'b0 && n < 64);
    q = av_rdata;
    av_wr <= 1'b0;
    av_rd <= 1'b0;
    if (n >= 64) chk(40'h1, 40'h0, "bus hang");
  endtask : av
  // mode bit0 read, bit1 pace by ready flag
  task automatic xfer(input logic [1:0] mode, input logic [15:0] a,
                      input logic [15:0] d, output logic [15:0] q);
    logic [31:0] r;
    int          n;
    av(1'b1, `SSRA_CSR_ADDR, {16'h0000, a}, r);
    av(1'b1, `SSRA_CSR_WDATA, {16'h0000, d}, r);
    av(1'b1, `SSRA_CSR_CTRL, {30'h0, mode}, r);
    n = 0;
    do
    begin
      av(1'b0, `SSRA_CSR_STATUS, 32'h0, r);
      n++;
    end
    while (r[16] !== 1'b0 && n < 4000);
    if (n >= 4000) chk(40'h1, 40'h0, "transfer hang");
    q = r[15:0];
  endtask : xfer
  task automatic pulse_frame;
    @(posedge clk);
    frame_start <= 1'b1;
    @(posedge clk);
    frame_start <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : pulse_frame
  task automatic summarize;
    if (n_errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  // ==========================================================
  // scenarios
  task automatic t_reset;
    logic [15:0] q;
    chk({24'h0, line_length_act}, 40'h0, "line length reset");
    chk({24'h0, lvds_sel_act}, 40'h0, "lvds select reset");
    chk({39'h0, ssra_if_inst.read_ready_flag}, 40'h0, "flag reset");
    xfer(2'b01, `SSRA_ADDR_RDY_EN, 16'h0000, q);
    chk({24'h0, q}, 40'h0, "flag enable reset");
  endtask : t_reset
  // writes while streaming stay pending until their update point
  task automatic t_shadow;
    logic [15:0] q;
    op_state <= SSRA_OP_STREAM;
    xfer(2'b00, `SSRA_ADDR_LINE_LENGTH, 16'h0A5C, q);
    chk(wire_bits, {`SSRA_CMD_WRITE, `SSRA_ADDR_LINE_LENGTH, 16'h0A5C},
        "write frame");
    xfer(2'b00, `SSRA_ADDR_LVDS_SEL, 16'h0001, q);
    chk({24'h0, line_length_act}, 40'h0, "line length early");
    chk({24'h0, lvds_sel_act}, 40'h0, "lvds select early");
    xfer(2'b01, `SSRA_ADDR_LINE_LENGTH, 16'h0000, q);
    chk({24'h0, q}, 40'h0A5C, "shadow readback");
    chk({16'h0, wire_bits[39:16]},
        {16'h0, `SSRA_CMD_READ, `SSRA_ADDR_LINE_LENGTH}, "read frame");
    pulse_frame();
    chk({24'h0, lvds_sel_act}, 40'h1, "lvds select at frame");
    chk({39'h0, sub_lvds_act}, 40'h1, "sub lvds mode");
    chk({24'h0, line_length_act}, 40'h0, "line length in stream");
    op_state <= SSRA_OP_SETUP;
    repeat (6) @(posedge clk);
    chk({24'h0, line_length_act}, 40'h0A5C, "line length at setup");
  endtask : t_shadow
  // paced read in setup, then back to standard lvds
  task automatic t_flag;
    logic [15:0] q;
    int          w0;
    xfer(2'b00, `SSRA_ADDR_RDY_EN, 16'h0001, q);
    pulse_frame();
    xfer(2'b01, `SSRA_ADDR_RDY_EN, 16'h0000, q);
    chk({24'h0, q}, 40'h1, "fast readback");
    w0 = wait_cyc;
    xfer(2'b11, `SSRA_ADDR_LVDS_SEL, 16'h0000, q);
    chk({24'h0, q}, 40'h1, "paced readback");
    chk({39'h0, (wait_cyc - w0) > FETCH_MAX}, 40'h0, "fetch too slow");
    xfer(2'b00, `SSRA_ADDR_LVDS_SEL, 16'h0000, q);
    pulse_frame();
    chk({39'h0, sub_lvds_act}, 40'h0, "standard lvds mode");
  endtask : t_flag
  // ==========================================================
  // main sequence and watchdog
  initial
  begin
    rst_b       = 1'b0;
    av_addr     = 4'h0;
    av_rd       = 1'b0;
    av_wr       = 1'b0;
    av_wdata    = 32'h0;
    op_state    = SSRA_OP_SETUP;
    frame_start = 1'b0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_shadow();
    t_flag();
    summarize();
  end
  // whole run needs about 9k cycles
  initial
  begin
    #250000;
    n_errors++;
    summarize();
  end
endmodule : sensor_spi_register_access_bench
